// [design/micx_params.svh]
// micx_params.svh: constants for the instruction execution unit.
// assumes inclusion by design files only; definitions, no logic.
`ifndef MICX_PARAMS_SVH
`define MICX_PARAMS_SVH
`define MICX_DATA_W 8
`define MICX_ADDR_W 8
`define MICX_PC_W 12
`define MICX_ACC_RST 8'h00
`define MICX_PC_RST 12'h000
`define MICX_ONE 8'h01
`define MICX_JUMP_CYCLES 2
`endif

// [design/micx_pkg.sv]
// micx_pkg.sv: types shared by the execution unit files.
// assumes micx_params.svh is on the include path.
`include "micx_params.svh"
package micx_pkg;
    typedef enum logic [3:0] {
        MICX_OP_NOP,
        MICX_OP_DEC_M,
        MICX_OP_DEC_A,
        MICX_OP_INC_M,
        MICX_OP_INC_A,
        MICX_OP_HALT,
        MICX_OP_JUMP,
        MICX_OP_LD_M,
        MICX_OP_LD_I,
        MICX_OP_ST
    } micx_op_t;

    typedef struct packed {
        micx_op_t op;
        logic [`MICX_ADDR_W-1:0] addr;
        logic [`MICX_DATA_W-1:0] imm;
        logic [`MICX_PC_W-1:0] target;
    } micx_instr_t;

    typedef struct packed {
        logic power_down_flag;
        logic watchdog_timeout_flag;
        logic zero_flag;
    } micx_flags_t;
endpackage

// [design/micx_alu.sv]
// micx_alu.sv: increment/decrement unit with zero detection.
// assumes a purely combinational use inside the execution unit.
`timescale 1ns/1ps
`default_nettype none
module micx_alu
    import micx_pkg::*;
#(
    parameter int DW = `MICX_DATA_W
) (
    // operand and select
    input wire logic [DW-1:0] operand,
    input wire logic decrement,
    // result
    output logic [DW-1:0] result,
    output logic is_zero
);
    wire logic [DW-1:0] one = DW'(`MICX_ONE);
    assign result = decrement ? operand - one : operand + one;
    assign is_zero = (result == '0);
endmodule
`default_nettype wire

// [design/micx_exec.sv]
// micx_exec.sv: executes inc/dec, move, jump and power-down instructions.
// assumes one instruction offered per cycle with instr_valid, data memory
// read combinationally through mem_rdata at mem_addr.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - decrement memory, write back, update zero
// - decrement into accumulator, memory kept, zero
// - power-down stops execution, gates clock, keeps state
// - power-down clears watchdog counter and prescaler
// - power-down sets pd flag, clears timeout
// - increment memory, write back, update zero
// - increment into accumulator, memory kept, zero
// - jump loads pc with target, no flags
// - jump takes two cycles, dummy second
// - load accumulator from memory, flags kept
// - load accumulator immediate, flags kept
// - store accumulator to memory, flags kept
module micx_exec
    import micx_pkg::*;
#(
    parameter int DW = `MICX_DATA_W,
    parameter int AW = `MICX_ADDR_W,
    parameter int PW = `MICX_PC_W
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // instruction in
    input wire micx_instr_t instr,
    input wire logic instr_valid,
    // wake from power down and watchdog timeout event
    input wire logic wake,
    input wire logic watchdog_timeout,
    // data memory
    input wire logic [DW-1:0] mem_rdata,
    output logic [AW-1:0] mem_addr,
    output logic [DW-1:0] mem_wdata,
    output logic mem_we,
    // core state
    output logic [DW-1:0] accumulator_register,
    output logic [PW-1:0] pc,
    output micx_flags_t flags,
    // status and control
    output logic instr_ready,
    output logic dummy_cycle,
    output logic sys_clk_en,
    output logic watchdog_clear
);
    typedef enum logic [1:0] {
        MICX_RUN,
        MICX_JUMP2,
        MICX_SLEEP
    } micx_state_t;

    micx_state_t state;
    micx_state_t next_state;

    wire logic take = instr_valid && (state == MICX_RUN);
    wire micx_op_t op = instr.op;
    wire logic is_dec = (op == MICX_OP_DEC_M) || (op == MICX_OP_DEC_A);
    wire logic is_incdec = is_dec || (op == MICX_OP_INC_M)
                           || (op == MICX_OP_INC_A);
    wire logic to_mem = (op == MICX_OP_DEC_M) || (op == MICX_OP_INC_M);
    wire logic [DW-1:0] alu_result;
    wire logic alu_zero;

    micx_alu #(.DW(DW)) u_alu (
        .operand(mem_rdata),
        .decrement(is_dec),
        .result(alu_result),
        .is_zero(alu_zero)
    );

    // memory address follows the instruction combinationally for the read;
    // write strobe and data below are registered, the address is not
    assign mem_addr = instr.addr;

    wire logic wr_incdec = take && is_incdec && to_mem;
    wire logic wr_store = take && (op == MICX_OP_ST);
    wire logic [DW-1:0] next_wdata = wr_store ? accumulator_register
                                              : alu_result;
    wire logic acc_incdec = take && is_incdec && !to_mem;
    wire logic acc_mem = take && (op == MICX_OP_LD_M);
    wire logic acc_imm = take && (op == MICX_OP_LD_I);
    wire logic do_halt = take && (op == MICX_OP_HALT);
    wire logic do_jump = take && (op == MICX_OP_JUMP);
    wire logic step = take && !do_halt && !do_jump;

    always_comb begin
        next_state = state;
        case (state)
            MICX_RUN: begin
                if (do_jump) begin
                    next_state = MICX_JUMP2;
                end else if (do_halt) begin
                    next_state = MICX_SLEEP;
                end
            end
            MICX_JUMP2: next_state = MICX_RUN;
            MICX_SLEEP: begin
                if (wake) begin
                    next_state = MICX_RUN;
                end
            end
            default: next_state = MICX_RUN;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= MICX_RUN;
        end else begin
            state <= next_state;
        end
    end

    // memory write port, registered
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mem_we <= 1'b0;
            mem_wdata <= '0;
        end else begin
            mem_we <= wr_incdec || wr_store;
            mem_wdata <= next_wdata;
        end
    end

    // accumulator; inc/dec to memory leaves it alone
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            accumulator_register <= DW'(`MICX_ACC_RST);
        end else if (acc_incdec) begin
            accumulator_register <= alu_result;
        end else if (acc_mem) begin
            accumulator_register <= mem_rdata;
        end else if (acc_imm) begin
            accumulator_register <= instr.imm;
        end
    end

    // program counter; the jump loads the target in its first cycle and the
    // second cycle is the dummy slot, so fetch resumes at the target after it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pc <= PW'(`MICX_PC_RST);
        end else if (do_jump) begin
            pc <= instr.target;
        end else if (step) begin
            pc <= pc + PW'(1);
        end
    end

    // only inc/dec touch zero; moves, jump and halt leave it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flags <= '0;
        end else begin
            if (take && is_incdec) begin
                flags.zero_flag <= alu_zero;
            end
            if (do_halt) begin
                flags.power_down_flag <= 1'b1;
                flags.watchdog_timeout_flag <= 1'b0;
            end else if (watchdog_timeout) begin
                flags.watchdog_timeout_flag <= 1'b1;
            end
        end
    end

    // halt holds off further instructions; data memory, accumulator and pc are
    // untouched because their updates above are gated by take (timeout flag is not)
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            instr_ready <= 1'b1;
            dummy_cycle <= 1'b0;
            sys_clk_en <= 1'b1;
            watchdog_clear <= 1'b0;
        end else begin
            instr_ready <= (next_state == MICX_RUN);
            dummy_cycle <= do_jump;
            sys_clk_en <= (next_state != MICX_SLEEP);
            watchdog_clear <= do_halt;
        end
    end
endmodule
`default_nettype wire

// [test/micx_exec_sva.sv]
// micx_exec_sva.sv: port assertions for the execution unit.
// assumes a bind onto micx_exec; results land one cycle after taking.
`timescale 1ns/1ps
`default_nettype none
module micx_exec_sva
    import micx_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // inputs
    input wire micx_instr_t instr,
    input wire logic instr_valid,
    input wire logic [7:0] mem_rdata,
    // outputs
    input wire logic [7:0] mem_wdata,
    input wire logic mem_we,
    input wire logic [7:0] accumulator_register,
    input wire logic [11:0] pc,
    input wire micx_flags_t flags,
    input wire logic instr_ready,
    input wire logic dummy_cycle,
    input wire logic sys_clk_en,
    input wire logic watchdog_clear
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic tk;
    micx_op_t op;
    logic [7:0] ld_val;
    assign tk = instr_valid && instr_ready;
    assign op = instr.op;
    assign ld_val = (op == MICX_OP_LD_M) ? mem_rdata : instr.imm;
    chk_dec_mem: assert property (
        tk && op == MICX_OP_DEC_M |=> mem_we
        && mem_wdata == $past(mem_rdata) - 8'h01) else $error("dec mem");
    chk_dec_acc: assert property (
        tk && op == MICX_OP_DEC_A |=> !mem_we
        && accumulator_register == $past(mem_rdata) - 8'h01)
        else $error("dec acc");
    chk_inc_mem: assert property (
        tk && op == MICX_OP_INC_M |=> mem_we
        && mem_wdata == $past(mem_rdata) + 8'h01) else $error("inc mem");
    chk_inc_acc: assert property (
        tk && op == MICX_OP_INC_A |=> !mem_we
        && accumulator_register == $past(mem_rdata) + 8'h01)
        else $error("inc acc");
    chk_zero_flag: assert property (
        tk && op inside {MICX_OP_DEC_M, MICX_OP_DEC_A, MICX_OP_INC_M,
        MICX_OP_INC_A} |=> flags.zero_flag == (mem_we ?
        mem_wdata == 8'h00 : accumulator_register == 8'h00))
        else $error("zero flag");
    chk_halt_flags: assert property (
        tk && op == MICX_OP_HALT |=> flags.power_down_flag
        && !flags.watchdog_timeout_flag && $stable(flags.zero_flag))
        else $error("halt flags");
    chk_halt_stop: assert property (
        tk && op == MICX_OP_HALT |=> watchdog_clear && !sys_clk_en
        && !instr_ready && !mem_we && $stable(accumulator_register))
        else $error("halt stop");
    chk_jump_pc: assert property (
        tk && op == MICX_OP_JUMP |=> pc == $past(instr.target)
        && $stable(flags)) else $error("jump pc");
    chk_jump_dummy: assert property (
        tk && op == MICX_OP_JUMP |=> dummy_cycle && !instr_ready
        ##1 instr_ready) else $error("jump dummy");
    chk_load_acc: assert property (
        tk && op inside {MICX_OP_LD_M, MICX_OP_LD_I} |=>
        accumulator_register == $past(ld_val) && $stable(flags))
        else $error("load acc");
    chk_store_mem: assert property (
        tk && op == MICX_OP_ST |=> mem_we && $stable(flags)
        && mem_wdata == $past(accumulator_register)) else $error("store");
    cover property (tk && op == MICX_OP_JUMP);
    cover property (tk && op == MICX_OP_HALT);
    cover property (mem_we && mem_wdata == 8'h00);
endmodule
bind micx_exec micx_exec_sva u_sva (.*);
`default_nettype wire

// [test/test_micx_exec.sv]
// test_micx_exec.sv: directed run through every covered operation.
// assumes memory reads back its own address; writes are only observed.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("CHECK FAILED at %0t: value mismatch", $time); end end
module test_micx_exec
    import micx_pkg::*;
;
    logic clk_sys = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, to_req = 1'b0;
    logic wake = 1'b0, watchdog_timeout = 1'b0;
    micx_instr_t instr = '0;
    logic [7:0] mem_rdata, mem_addr, mem_wdata, accumulator_register;
    logic [11:0] pc;
    logic mem_we, instr_ready, dummy_cycle, sys_clk_en, watchdog_clear;
    micx_flags_t flags;
    int n_mismatch = 0, checks = 0;
    always #2 clk_sys = ~clk_sys;
    assign mem_rdata = mem_addr;
    micx_exec dut (.*);
    task automatic print_verdict;
        if (n_mismatch == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic issue(micx_op_t o, logic [7:0] a, logic [11:0] t);
        @(posedge clk_sys);
        instr <= '{o, a, a, t};
        instr_valid <= 1'b1;
        watchdog_timeout <= to_req;
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        watchdog_timeout <= 1'b0;
        #1;
    endtask
    initial begin
        repeat (2000) @(posedge clk_sys);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        issue(MICX_OP_INC_A, 8'h7F, 12'h000);
        `CHK({accumulator_register, flags, pc}, {8'h80, 3'h0, 12'h001})
        issue(MICX_OP_DEC_A, 8'h00, 12'h000);
        `CHK({accumulator_register, flags, mem_we}, {8'hFF, 3'h0, 1'b0})
        issue(MICX_OP_DEC_M, 8'h01, 12'h000);
        `CHK({mem_we, mem_wdata, flags}, {1'b1, 8'h00, 3'h1})
        issue(MICX_OP_LD_I, 8'h00, 12'h000);
        `CHK({accumulator_register, flags}, {8'h00, 3'h1})
        issue(MICX_OP_LD_M, 8'h5A, 12'h000);
        `CHK({accumulator_register, flags}, {8'h5A, 3'h1})
        issue(MICX_OP_ST, 8'h10, 12'h000);
        `CHK({mem_we, mem_wdata, flags}, {1'b1, 8'h5A, 3'h1})
        `CHK(mem_addr, 8'h10)
        issue(MICX_OP_JUMP, 8'h00, 12'hABC);
        `CHK({pc, dummy_cycle, instr_ready}, {12'hABC, 2'h2})
        @(posedge clk_sys);
        #1;
        `CHK(instr_ready, 1'b1)
        issue(MICX_OP_INC_M, 8'h05, 12'h000);
        `CHK({mem_wdata, flags, pc}, {8'h06, 3'h0, 12'hABD})
        to_req = 1'b1;
        issue(MICX_OP_NOP, 8'h00, 12'h000);
        `CHK(flags, 3'h2)
        // timeout raised in the same cycle as halt must lose
        issue(MICX_OP_HALT, 8'h00, 12'h000);
        to_req = 1'b0;
        `CHK({flags, watchdog_clear, sys_clk_en}, {3'h4, 2'h2})
        issue(MICX_OP_INC_A, 8'h20, 12'h000);
        `CHK({accumulator_register, instr_ready}, {8'h5A, 1'b0})
        @(posedge clk_sys);
        wake <= 1'b1;
        @(posedge clk_sys);
        wake <= 1'b0;
        #1;
        `CHK({instr_ready, sys_clk_en}, 2'h3)
        issue(MICX_OP_INC_A, 8'h01, 12'h000);
        `CHK({accumulator_register, flags}, {8'h02, 3'h4})
        print_verdict();
    end
endmodule
`default_nettype wire
